// file: src/racr_clkdiv.sv
`timescale 1ns/10ps
module racr_clkdiv #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] div,
   output logic              clk_out
);
   logic [W-1:0] cnt_q;
   logic         out_q;

   // divide by div (div 1 toggles each cycle, dividing by 2): high for div/2 cycles, low for the rest
   always_ff @(posedge mclk) begin
      if (!rstn || div == '0) begin
         cnt_q <= '0;
      end else if (cnt_q >= div - W'(1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn || div == '0) begin
         out_q <= 1'b0;
      end else begin
         out_q <= (div == W'(1)) ? ~out_q : (cnt_q < (div >> 1));
      end
   end

   assign clk_out = out_q;
endmodule

// file: src/racr_pkg.sv
package racr_pkg;
   localparam logic [9:0] FCL_OFS   = 10'h315;
   localparam logic [9:0] IRC_OFS   = 10'h319;
   localparam logic [9:0] SDR_OFS   = 10'h322;
   localparam logic [9:0] RXP_OFS   = 10'h324;
   localparam logic [9:0] AXP_OFS   = 10'h325;
   localparam logic [9:0] CRH_OFS   = 10'h327;
   localparam logic [9:0] CRL_OFS   = 10'h328;
   localparam logic [9:0] BTT_OFS   = 10'h32D;
   localparam logic [9:0] ACD_OFS   = 10'h32E;
   localparam logic [7:0] FCL_RST   = 8'h32;
   localparam logic [3:0] ACD_RST   = 4'h4;
   localparam int         IRC_OVR_BIT = 5;
   localparam int         BAT_ALARM_BIT = 7;
   localparam logic [11:0] BMV_RST      = 12'hFFF;
   localparam logic [11:0] BAT_BASE_MV  = 12'h6A4;
   localparam logic [6:0]  BAT_STEP_MV  = 7'h3E;
endpackage

// file: src/racr_regs.sv
// Contract
// - an 8-bit pull-in limit resets to 50 and is rewritten on each entry to receive.
// - the automatic value is half the selected IF bandwidth in kHz.
// - bit 5 of the image calibration register makes user values replace calibration results.
// - the 2-bit source frequency selects off, xtal/4, xtal/8 or xtal/16.
// - the 3-bit source power maps 0 off, 1-2 min, 3-4 x2, 5-6 x3, 7 x4.
// - shutdown starts only when the request bit is 1 and chip select is high.
// - receive power bits are active-high enables resetting to 0, bit 4 enables the amplifier.
// - auxiliary bits enable the temperature (bit 1) and battery (bit 0) monitors.
// - the converter result reads split: bits 7:2 in high[5:0], bits 1:0 in low[7:6].
// - a 5-bit code sets the trip voltage to 1.7 V plus 62 mV per step.
// - a battery trip is reported through the interrupt path, not a status register.
// - the aux pin carries the crystal clock divided by a 4-bit value resetting to 4; a value of 1 divides by 2 here.
// - a divider of zero switches the aux clock off.
// - the battery alarm is bit 7 of the second interrupt source, set on low battery.
`timescale 1ns/10ps
module racr_regs #(
   parameter int AW = 10
) (
   input  wire logic          mclk,
   input  wire logic          rstn,
   input  wire logic          wr_en,
   input  wire logic          rd_en,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic [7:0]         rdata,
   output logic               rvalid,
   input  wire logic          cs_pin,
   input  wire logic          rx_entry,
   input  wire logic [1:0]    if_bw_sel,
   input  wire logic [7:0]    conv_result,
   input  wire logic [11:0]   batt_mv,
   output logic               shutdown_go,
   output logic [4:0]         rx_power_on,
   output logic               temperature_monitor_on,
   output logic               battery_monitor_on,
   output logic               image_cal_result_override,
   output logic [1:0]         cal_src_div_sel,
   output logic [2:0]         cal_src_level,
   output logic [11:0]        battery_trip_mv,
   output logic               battery_alarm_event,
   output logic [7:0]         irq_source1_bits,
   output logic               aux_clock_out_pin
);
   logic [7:0]  fcl_q;
   logic [5:0]  irc_q;
   logic        sdr_q;
   logic [4:0]  rxp_q;
   logic [1:0]  axp_q;
   logic [4:0]  btt_q;
   logic [3:0]  acd_q;
   logic [7:0]  conv_q;
   logic [7:0]  fcl_auto;
   logic        cs_m_q, cs_s_q;
   logic        rxe_m_q, rxe_s_q, rxe_d_q;
   logic [11:0] bmv_m_q, bmv_s_q, bmv_d_q;
   logic [11:0] bmv_q;
   logic        below_q;
   logic        alarm_q;
   logic [7:0]  rdata_q;
   logic        rvalid_q;
   logic [2:0]  lvl;
   logic [11:0] trip;
   logic [2:0]  lvl_q;
   logic [11:0] trip_q;
   logic        sd_go_q;

   // external levels pass two flops before use
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cs_m_q  <= 1'b0;
         cs_s_q  <= 1'b0;
         rxe_m_q <= 1'b0;
         rxe_s_q <= 1'b0;
         rxe_d_q <= 1'b0;
         bmv_m_q <= racr_pkg::BMV_RST;
         bmv_s_q <= racr_pkg::BMV_RST;
         bmv_d_q <= racr_pkg::BMV_RST;
      end else begin
         cs_m_q  <= cs_pin;
         cs_s_q  <= cs_m_q;
         rxe_m_q <= rx_entry;
         rxe_s_q <= rxe_m_q;
         rxe_d_q <= rxe_s_q;
         bmv_m_q <= batt_mv;
         bmv_s_q <= bmv_m_q;
         bmv_d_q <= bmv_s_q;
      end
   end

   // a multi-bit level may be caught mid-change, take it once two samples agree
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         bmv_q <= racr_pkg::BMV_RST;
      end else if (bmv_s_q == bmv_d_q) begin
         bmv_q <= bmv_d_q;
      end
   end

   // half of 100/150/200/300 khz
   always_comb begin
      case (if_bw_sel)
         2'h0:    fcl_auto = 8'h32;
         2'h1:    fcl_auto = 8'h4B;
         2'h2:    fcl_auto = 8'h64;
         default: fcl_auto = 8'h96;
      endcase
   end

   // automatic update on receive entry wins over a host write in the same cycle
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         fcl_q <= racr_pkg::FCL_RST;
      end else if (rxe_s_q && !rxe_d_q) begin
         fcl_q <= fcl_auto;
      end else if (wr_en && addr == racr_pkg::FCL_OFS) begin
         fcl_q <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irc_q <= '0;
         sdr_q <= 1'b0;
         rxp_q <= '0;
         axp_q <= '0;
         btt_q <= '0;
         acd_q <= racr_pkg::ACD_RST;
      end else if (wr_en) begin
         case (addr)
            racr_pkg::IRC_OFS: irc_q <= wdata[5:0];
            racr_pkg::SDR_OFS: sdr_q <= wdata[0];
            racr_pkg::RXP_OFS: rxp_q <= wdata[4:0];
            racr_pkg::AXP_OFS: axp_q <= wdata[1:0];
            racr_pkg::BTT_OFS: btt_q <= wdata[4:0];
            racr_pkg::ACD_OFS: acd_q <= wdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         conv_q <= '0;
      end else begin
         conv_q <= conv_result;
      end
   end

   assign rx_power_on               = rxp_q;
   assign temperature_monitor_on    = axp_q[1];
   assign battery_monitor_on        = axp_q[0];
   assign image_cal_result_override = irc_q[racr_pkg::IRC_OVR_BIT];
   assign cal_src_div_sel           = irc_q[4:3];

   // pairs of codes share one level, 0 is off
   always_comb begin
      case (irc_q[2:0])
         3'h0:       lvl = 3'h0;
         3'h1, 3'h2: lvl = 3'h1;
         3'h3, 3'h4: lvl = 3'h2;
         3'h5, 3'h6: lvl = 3'h3;
         default:    lvl = 3'h4;
      endcase
   end

   assign trip = racr_pkg::BAT_BASE_MV + 12'(btt_q) * 12'(racr_pkg::BAT_STEP_MV);

   // decoded outputs leave from flops so the analog side never sees a decode glitch
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sd_go_q <= 1'b0;
         lvl_q   <= 3'h0;
         trip_q  <= racr_pkg::BAT_BASE_MV;
      end else begin
         sd_go_q <= sdr_q & cs_s_q;
         lvl_q   <= lvl;
         trip_q  <= trip;
      end
   end
   assign shutdown_go     = sd_go_q;
   assign cal_src_level   = lvl_q;
   assign battery_trip_mv = trip_q;

   // the alarm edge goes to the interrupt logic, no status register here
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         below_q <= 1'b0;
         alarm_q <= 1'b0;
      end else begin
         below_q <= axp_q[0] && (bmv_q < trip);
         alarm_q <= axp_q[0] && (bmv_q < trip) && !below_q;
      end
   end
   assign battery_alarm_event = alarm_q;
   assign irq_source1_bits    = 8'(alarm_q) << racr_pkg::BAT_ALARM_BIT;

   racr_clkdiv #(
      .W (4)
   ) u_div (
      .mclk    (mclk),
      .rstn    (rstn),
      .div     (acd_q),
      .clk_out (aux_clock_out_pin)
   );

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_q  <= '0;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_en;
         if (rd_en) begin
            case (addr)
               racr_pkg::FCL_OFS: rdata_q <= fcl_q;
               racr_pkg::IRC_OFS: rdata_q <= {2'h0, irc_q};
               racr_pkg::SDR_OFS: rdata_q <= {7'h00, sdr_q};
               racr_pkg::RXP_OFS: rdata_q <= {3'h0, rxp_q};
               racr_pkg::AXP_OFS: rdata_q <= {6'h00, axp_q};
               racr_pkg::CRH_OFS: rdata_q <= {2'h0, conv_q[7:2]};
               racr_pkg::CRL_OFS: rdata_q <= {conv_q[1:0], 6'h00};
               racr_pkg::BTT_OFS: rdata_q <= {3'h0, btt_q};
               racr_pkg::ACD_OFS: rdata_q <= {4'h0, acd_q};
               default:           rdata_q <= 8'h00;
            endcase
         end
      end
   end
   assign rdata  = rdata_q;
   assign rvalid = rvalid_q;

   chk_shutdown_needs_cs: assert property (@(posedge mclk) disable iff (!rstn)
      shutdown_go |-> ($past(sdr_q) && $past(cs_pin, 3)))
      else $error("shutdown without request and chip select");
   chk_limit_reset_value: assert property (@(posedge mclk)
      !rstn |=> fcl_q == 8'h32)
      else $error("pull-in limit reset wrong");
   chk_limit_auto_set: assert property (@(posedge mclk) disable iff (!rstn)
      (rxe_s_q && !rxe_d_q) |=> fcl_q == $past(fcl_auto))
      else $error("pull-in limit not set on receive entry");
   chk_split_readback: assert property (@(posedge mclk) disable iff (!rstn)
      (rd_en && addr == racr_pkg::CRL_OFS) |=> rdata[5:0] == 6'h00)
      else $error("reserved low readback bits set");
   chk_div_zero_off: assert property (@(posedge mclk) disable iff (!rstn)
      (acd_q == 4'h0) [*2] |-> !aux_clock_out_pin)
      else $error("aux clock runs with divider zero");
   chk_alarm_one_pulse: assert property (@(posedge mclk) disable iff (!rstn)
      alarm_q |=> !alarm_q)
      else $error("battery alarm longer than one cycle");
   chk_alarm_needs_on: assert property (@(posedge mclk) disable iff (!rstn)
      irq_source1_bits[7] |-> $past(axp_q[0]))
      else $error("alarm with battery monitor off");
   chk_level_max: assert property (@(posedge mclk) disable iff (!rstn)
      (irc_q[2:0] == 3'h7) |=> cal_src_level == 3'h4)
      else $error("source level code 7 wrong");
   chk_limit_half_bw: assert property (@(posedge mclk) disable iff (!rstn)
      (rxe_s_q && !rxe_d_q) |=> fcl_q == ($past(if_bw_sel) == 2'h3 ? 8'h96 :
         8'h32 + 8'h19 * {6'h00, $past(if_bw_sel)}))
      else $error("pull-in limit not half the bandwidth");
   chk_limit_host_write: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_en && addr == racr_pkg::FCL_OFS && !(rxe_s_q && !rxe_d_q))
         |=> fcl_q == $past(wdata))
      else $error("pull-in limit write lost");
   chk_override_write: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_en && addr == racr_pkg::IRC_OFS)
         |=> image_cal_result_override == $past(wdata[racr_pkg::IRC_OVR_BIT]))
      else $error("override enable not taken");
   chk_src_div_write: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_en && addr == racr_pkg::IRC_OFS) |=> cal_src_div_sel == $past(wdata[4:3]))
      else $error("source divider select not taken");
   chk_level_off: assert property (@(posedge mclk) disable iff (!rstn)
      (irc_q[2:0] == 3'h0) |=> cal_src_level == 3'h0)
      else $error("source level not off for code 0");
   chk_shutdown_needs_bit: assert property (@(posedge mclk) disable iff (!rstn)
      !sdr_q |=> !shutdown_go)
      else $error("shutdown without request bit");
   chk_rx_power_reset: assert property (@(posedge mclk)
      !rstn |=> rx_power_on == 5'h00)
      else $error("receive enables not cleared by reset");
   chk_rx_power_write: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_en && addr == racr_pkg::RXP_OFS) |=> rx_power_on == $past(wdata[4:0]))
      else $error("receive enables not taken");
   chk_monitor_write: assert property (@(posedge mclk) disable iff (!rstn)
      (wr_en && addr == racr_pkg::AXP_OFS)
         |=> {temperature_monitor_on, battery_monitor_on} == $past(wdata[1:0]))
      else $error("monitor enables not taken");
   chk_split_high: assert property (@(posedge mclk) disable iff (!rstn)
      (rd_en && addr == racr_pkg::CRH_OFS) |=> rdata[7:6] == 2'h0)
      else $error("reserved high readback bits set");
   chk_trip_base: assert property (@(posedge mclk) disable iff (!rstn)
      (btt_q == 5'h00) |=> battery_trip_mv == 12'h6A4)
      else $error("trip level for code 0 wrong");
   chk_trip_top: assert property (@(posedge mclk) disable iff (!rstn)
      (btt_q == 5'h1F) |=> battery_trip_mv == 12'hE26)
      else $error("trip level for top code wrong");
   chk_alarm_on_drop: assert property (@(posedge mclk) disable iff (!rstn)
      (axp_q[0] && bmv_q < trip && !below_q) |=> battery_alarm_event)
      else $error("battery drop not reported");
   chk_div_reset_value: assert property (@(posedge mclk)
      !rstn |=> acd_q == 4'h4)
      else $error("aux divider reset wrong");
   chk_reserved_read: assert property (@(posedge mclk) disable iff (!rstn)
      (rd_en && addr == racr_pkg::RXP_OFS) |=> rdata[7:5] == 3'h0)
      else $error("reserved receive power bits set");
   cov_shutdown:  cover property (@(posedge mclk) disable iff (!rstn) shutdown_go);
   cov_rx_entry:  cover property (@(posedge mclk) disable iff (!rstn) rxe_s_q && !rxe_d_q);
   cov_alarm:     cover property (@(posedge mclk) disable iff (!rstn) alarm_q);
   cov_aux_clock: cover property (@(posedge mclk) disable iff (!rstn) $rose(aux_clock_out_pin));
endmodule

// file: tb/racr_host.sv
`timescale 1ns/10ps
module racr_host (
   input  wire logic       mclk,
   input  wire logic [7:0] rdata,
   input  wire logic       rvalid,
   output logic            wr_en,
   output logic            rd_en,
   output logic [9:0]      addr,
   output logic [7:0]      wdata,
   output logic            cs_pin
);
   initial begin
      {wr_en, rd_en, addr, wdata, cs_pin} = '0;
   end
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      {wr_en, addr, wdata} <= {1'b1, a, d};
      @(posedge mclk);
      // released data bus must not look like a held value
      {wr_en, wdata} <= {1'b0, ~d};
      @(posedge mclk);
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      {rd_en, addr} <= {1'b1, a};
      @(posedge mclk);
      rd_en <= 1'b0;
      @(posedge mclk);
      d = (rvalid === 1'b1) ? rdata : 8'hXX;
   endtask
   // select must be high as well before the request bit can act
   task automatic cs(input logic v);
      cs_pin <= v;
   endtask
endmodule

// file: tb/test_radio_aux_control_registers.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
module test_radio_aux_control_registers;
   logic        mclk, rstn, rx_entry, wr_en, rd_en, cs_pin, rvalid, sd_go;
   logic        temp_on, batt_on, ovr, alarm, aux_pin;
   logic [1:0]  if_bw_sel, div_sel;
   logic [2:0]  level;
   logic [4:0]  rx_pwr;
   logic [7:0]  conv_result, wdata, rdata, irq1;
   logic [9:0]  addr;
   logic [11:0] batt_mv, trip_mv;
   int          err_total, n_tests, cyc;

   racr_host host (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .cs_pin(cs_pin));
   racr_regs #(.AW(10)) uut (.mclk(mclk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .cs_pin(cs_pin),
      .rx_entry(rx_entry), .if_bw_sel(if_bw_sel), .conv_result(conv_result),
      .batt_mv(batt_mv), .shutdown_go(sd_go), .rx_power_on(rx_pwr),
      .temperature_monitor_on(temp_on), .battery_monitor_on(batt_on),
      .image_cal_result_override(ovr), .cal_src_div_sel(div_sel), .cal_src_level(level),
      .battery_trip_mv(trip_mv), .battery_alarm_event(alarm), .irq_source1_bits(irq1),
      .aux_clock_out_pin(aux_pin));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [7:0] msk(input int a);
      case (a)
         10'h315: msk = 8'hFF;
         10'h319: msk = 8'h3F;
         10'h322: msk = 8'h01;
         10'h324, 10'h32D: msk = 8'h1F;
         10'h325: msk = 8'h03;
         10'h32E: msk = 8'h0F;
         default: msk = 8'h00;
      endcase
   endfunction

   task automatic rchk(input logic [9:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      `CHK("register read", e, d)
   endtask

   task automatic t_regs();
      for (int a = 10'h315; a <= 10'h32E; a++) begin
         rchk(a[9:0], a == 10'h315 ? 8'h32 : a == 10'h32E ? 8'h04 : 8'h00);
      end
      // unmapped and read-only places are written too and must stay zero
      for (int a = 10'h315; a <= 10'h32E; a++) host.wr(a[9:0], 8'hFF);
      for (int a = 10'h315; a <= 10'h32E; a++) rchk(a[9:0], msk(a));
      `CHK("enables", {5'h1F, 2'h3, 12'hE26}, {rx_pwr, temp_on, batt_on, trip_mv})
      for (int i = 0; i < 8; i++) begin
         host.wr(racr_pkg::IRC_OFS, {3'h1, i[1:0], i[2:0]});
         @(posedge mclk);
         `CHK("cal source", {1'b1, i[1:0], 3'((i + 1) / 2)}, {ovr, div_sel, level})
      end
      $display("test registers done");
   endtask

   task automatic t_shut();
      repeat (4) @(posedge mclk);
      `CHK("shutdown no select", 1'b0, sd_go)
      host.cs(1'b1);
      repeat (4) @(posedge mclk);
      `CHK("shutdown", 1'b1, sd_go)
      host.wr(racr_pkg::SDR_OFS, 8'h00);
      @(posedge mclk);
      `CHK("shutdown cleared", 1'b0, sd_go)
      host.cs(1'b0);
      $display("test shutdown done");
   endtask

   task automatic t_rx();
      for (int bw = 0; bw < 4; bw++) begin
         if_bw_sel <= bw[1:0];
         rx_entry <= 1'b1;
         repeat (5) @(posedge mclk);
         rx_entry <= 1'b0;
         repeat (3) @(posedge mclk);
         rchk(racr_pkg::FCL_OFS, 8'((bw == 3 ? 300 : 100 + 50 * bw) / 2));
      end
      conv_result <= 8'hB5;
      repeat (3) @(posedge mclk);
      rchk(racr_pkg::CRH_OFS, 8'h2D);
      rchk(racr_pkg::CRL_OFS, 8'h40);
      $display("test receive and converter done");
   endtask

   task automatic t_batt();
      int n;
      host.wr(racr_pkg::BTT_OFS, 8'hE0);
      @(posedge mclk);
      `CHK("trip level", 12'h6A4, trip_mv)
      n = 0;
      batt_mv <= 12'h640;
      repeat (8) begin
         @(posedge mclk);
         n += (irq1[7] === 1'b1 && alarm === 1'b1);
      end
      `CHK("alarm pulses", 1, n)
      batt_mv <= 12'hFFF;
      $display("test battery done");
   endtask

   task automatic t_aux(input logic [3:0] dv, input int e);
      int   n;
      logic p;
      host.wr(racr_pkg::ACD_OFS, {4'hA, dv});
      repeat (8) @(posedge mclk);
      n = 0;
      p = aux_pin;
      repeat (40) begin
         @(posedge mclk);
         n += (aux_pin === 1'b1 && p === 1'b0);
         p = aux_pin;
      end
      `CHK("aux clock edges", e, n)
      $display("test aux clock done");
   endtask

   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      {rstn, rx_entry, if_bw_sel, conv_result, err_total, n_tests, cyc} = '0;
      batt_mv = 12'hFFF;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      t_regs();
      t_shut();
      t_rx();
      t_batt();
      t_aux(4'h4, 10);
      t_aux(4'h5, 8);
      t_aux(4'h0, 0);
      end_sim();
   end
endmodule
